// >>> hw/tec_channel.sv
// Event counter channel of a 16-bit timer: counter, reload, pulse output.
// Assumes every input is synchronous to clk except the two pins, which are
// synchronised here; neighbour events are one-cycle pulses on clk.
// How it works
// RL1: count selected edge on count input pin
// RL2: count companion timer events as source
// RL3: count events of preceding channel
// RL4: count events of following channel
// RL5: software bit picks up or down
// RL6: reload on overflow or underflow, keep counting
// RL7: free-running mode wraps without reload
// RL8: period FFFFh-n+1 up, n+1 down
// RL9: run bit starts and stops counting
// RL10: interrupt request on each overflow or underflow
// RL11: value register read returns current count
// RL12: write while stopped loads reload and counter
// RL13: write while running loads reload only
// RL14: pulse output toggles on each wrap
// RL15: stopped normal polarity output drives low
// RL16: inverted polarity drives high while stopped
// RL17: pins are general port or timer function
// RL18: two-phase only on channels two to four
// RL19: two-phase direction from phase relationship
// RL20: normal two-phase counts input edges when output high
// RL21: times-four counts all edges, direction by phase
// RL22: channel two normal, four times-four, three selectable
// RL23: pins synchronised and edge detected first
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module tec_channel
  import tec_pkg::*;
#(
  parameter int CHAN = 3
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              clkEn,
  input  wire tec_req_type       req,
  output logic [TEC_DW-1:0]      rdata,
  input  wire tec_nbr_type       nbrEvt,
  input  wire logic              countInPin,
  input  wire logic              outPinIn,
  output logic                   outPinOut,
  output logic                   outPinOe,
  output logic                   wrapEvt,
  output logic                   irqReq
);

  localparam bit TWO_OK = (CHAN >= 2) && (CHAN <= 4);

  function automatic logic isWr(input tec_req_type r, input logic [3:0] a);
    return r.wr && (r.addr == a);
  endfunction

  logic                  run_r;
  logic [TEC_MODE_W-1:0] mode_r;
  logic [15:0]           count_r;
  logic [15:0]           reload_r;
  logic                  tog_r;
  logic [1:0]            inSync_r;
  logic [1:0]            ouSync_r;
  logic                  inPrev_r;
  logic                  ouPrev_r;

  logic        twoPh;
  logic        x4;
  logic        inRise;
  logic        inFall;
  logic        ouEdge;
  logic        step;
  logic        down;
  logic        wrap;
  logic [15:0] count_nxt;
  tec_src_type src;

  assign src = tec_src_type'(mode_r[TEC_MODE_SRC_LO +: 2]);

  // Only channels 2..4 see the two-phase bit; 2 is fixed normal, 4 fixed x4.
  assign twoPh = TWO_OK && mode_r[TEC_MODE_TWOPH];  // [RL18]
  assign x4    = (CHAN == 4) || ((CHAN == 3) && mode_r[TEC_MODE_X4]);  // [RL22]

  // Two-flop synchronisers; only the second stage is used further on.
  always_ff @(posedge clk) begin  // [RL23]
    if (!nrst) begin
      inSync_r <= 2'b00;
      ouSync_r <= 2'b00;
      inPrev_r <= 1'b0;
      ouPrev_r <= 1'b0;
    end else if (clkEn) begin
      inSync_r <= {inSync_r[0], countInPin};
      ouSync_r <= {ouSync_r[0], outPinIn};
      inPrev_r <= inSync_r[1];
      ouPrev_r <= ouSync_r[1];
    end
  end

  assign inRise = inSync_r[1] && !inPrev_r;
  assign inFall = !inSync_r[1] && inPrev_r;
  assign ouEdge = ouSync_r[1] ^ ouPrev_r;

  // Count step and direction.
  always_comb begin
    step = 1'b0;
    down = mode_r[TEC_MODE_DOWN];  // [RL5]
    if (twoPh) begin
      if (x4) begin
        // Up when the input phase equals the other phase after an input edge,
        // or differs from it after an output-phase edge.
        step = inRise || inFall || ouEdge;  // [RL21]
        down = (inRise || inFall) ? (inSync_r[1] != ouSync_r[1])
                                  : (inSync_r[1] == ouSync_r[1]);  // [RL19]
      end else begin
        step = ouSync_r[1] && (inRise || inFall);  // [RL20]
        down = inFall;  // [RL19]
      end
    end else begin
      case (src)
        TEC_SRC_PIN:  step = mode_r[TEC_MODE_EDGE] ? inFall : inRise;  // [RL1]
        TEC_SRC_COMP: step = nbrEvt.comp;  // [RL2]
        TEC_SRC_PREV: step = nbrEvt.prev;  // [RL3]
        TEC_SRC_NEXT: step = nbrEvt.next;  // [RL4]
        default:      step = 1'b0;
      endcase
    end
  end

  // Wrap at FFFFh going up and at 0000h going down gives the stated periods.
  assign wrap = run_r && step &&
                (down ? (count_r == TEC_COUNT_MIN) : (count_r == TEC_COUNT_MAX));  // [RL8]

  always_comb begin
    count_nxt = count_r;
    if (isWr(req, TEC_OFS_VALUE) && !run_r) begin
      count_nxt = req.wdata;  // [RL12]
    end else if (run_r && step) begin  // [RL9]
      if (wrap && !mode_r[TEC_MODE_FREE]) begin
        count_nxt = reload_r;  // [RL6]
      end else if (down) begin
        count_nxt = count_r - 16'h0001;  // [RL7]
      end else begin
        count_nxt = count_r + 16'h0001;  // [RL7]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_r <= TEC_VALUE_RST;
    end else if (clkEn) begin
      count_r <= count_nxt;
    end
  end

  // Reload register takes every value write, running or not.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reload_r <= TEC_VALUE_RST;
    end else if (clkEn && isWr(req, TEC_OFS_VALUE)) begin
      reload_r <= req.wdata;  // [RL13]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      run_r  <= 1'b0;
      mode_r <= TEC_MODE_RST;
    end else if (clkEn) begin
      if (isWr(req, TEC_OFS_START)) begin
        run_r <= req.wdata[TEC_START_RUN];  // [RL9]
      end
      if (isWr(req, TEC_OFS_MODE)) begin
        mode_r <= req.wdata[TEC_MODE_W-1:0];
      end
    end
  end

  // Event pulses out: wrap for neighbours, interrupt request for the core.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrapEvt <= 1'b0;
      irqReq  <= 1'b0;
    end else if (clkEn) begin
      wrapEvt <= wrap;
      irqReq  <= wrap;  // [RL10]
    end else begin
      wrapEvt <= 1'b0;
      irqReq  <= 1'b0;
    end
  end

  // Pulse output: toggle state cleared while stopped, then polarity applied.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tog_r <= 1'b0;
    end else if (clkEn) begin
      if (!run_r) begin
        tog_r <= 1'b0;  // [RL15]
      end else if (wrap) begin
        tog_r <= !tog_r;  // [RL14]
      end
    end
  end

  // Pin is driven only as pulse output; otherwise it is a general port.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      outPinOut <= 1'b0;
      outPinOe  <= 1'b0;
    end else if (clkEn) begin
      outPinOe  <= mode_r[TEC_MODE_PULSE] && !twoPh;  // [RL17]
      outPinOut <= (run_r ? tog_r : 1'b0) ^ mode_r[TEC_MODE_INV];  // [RL16]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (clkEn) begin
      rdata <= 16'h0000;
      if (req.rd) begin
        case (req.addr)
          TEC_OFS_START: rdata <= {15'h0000, run_r};
          TEC_OFS_VALUE: rdata <= count_r;  // [RL11]
          TEC_OFS_MODE:  rdata <= {7'h00, mode_r};
          TEC_OFS_PINS:  rdata <= {13'h0000, tog_r, ouSync_r[1], inSync_r[1]};
          default:       rdata <= 16'h0000;
        endcase
      end
    end
  end

  a_stop_count_hold: assert property (@(posedge clk) disable iff (!nrst)  // [RL9]
    (clkEn && !run_r && !isWr(req, TEC_OFS_VALUE)) |=> $stable(count_r))
    else $error("Counter moved while stopped.");

  a_irq_on_wrap: assert property (@(posedge clk) disable iff (!nrst)  // [RL10]
    (clkEn && wrap) |=> irqReq)
    else $error("Missing interrupt after wrap.");

  a_reload_on_wrap: assert property (@(posedge clk) disable iff (!nrst)  // [RL6]
    (clkEn && wrap && !mode_r[TEC_MODE_FREE] && !isWr(req, TEC_OFS_VALUE))
      |=> count_r == $past(reload_r))
    else $error("Counter not reloaded.");

  a_free_wraps: assert property (@(posedge clk) disable iff (!nrst)  // [RL7]
    (clkEn && wrap && mode_r[TEC_MODE_FREE] && !down)
      |=> count_r == TEC_COUNT_MIN)
    else $error("Free-running counter did not wrap.");

  a_stopped_write: assert property (@(posedge clk) disable iff (!nrst)  // [RL12]
    (clkEn && !run_r && isWr(req, TEC_OFS_VALUE))
      |=> (count_r == $past(req.wdata)) && (reload_r == $past(req.wdata)))
    else $error("Stopped write missed counter.");

  a_running_write: assert property (@(posedge clk) disable iff (!nrst)  // [RL13]
    (clkEn && run_r && !step && isWr(req, TEC_OFS_VALUE)) |=> $stable(count_r))
    else $error("Running write reached counter.");

  a_read_count: assert property (@(posedge clk) disable iff (!nrst)  // [RL11]
    (clkEn && req.rd && req.addr == TEC_OFS_VALUE) |=> rdata == $past(count_r))
    else $error("Read did not return count.");

  a_stop_out_level: assert property (@(posedge clk) disable iff (!nrst)  // [RL15]
    (clkEn && !run_r) |=> outPinOut == $past(mode_r[TEC_MODE_INV]))
    else $error("Stopped output level wrong.");

  // Source selection, step direction, event pulses and pin handling.
  a_pin_edge_sel: assert property (@(posedge clk) disable iff (!nrst)  // [RL1]
    (!twoPh && src == TEC_SRC_PIN)
      |-> step == ((inRise && !mode_r[TEC_MODE_EDGE]) || (inFall && mode_r[TEC_MODE_EDGE])))
    else $error("Pin edge selection wrong.");

  a_comp_source: assert property (@(posedge clk) disable iff (!nrst)  // [RL2]
    (!twoPh && src == TEC_SRC_COMP) |-> step == nbrEvt.comp)
    else $error("Companion event not counted.");

  a_prev_source: assert property (@(posedge clk) disable iff (!nrst)  // [RL3]
    (!twoPh && src == TEC_SRC_PREV) |-> step == nbrEvt.prev)
    else $error("Preceding channel event not counted.");

  a_next_source: assert property (@(posedge clk) disable iff (!nrst)  // [RL4]
    (!twoPh && src == TEC_SRC_NEXT) |-> step == nbrEvt.next)
    else $error("Following channel event not counted.");

  a_up_step: assert property (@(posedge clk) disable iff (!nrst)  // [RL5]
    (clkEn && run_r && step && !down && !wrap)
      |=> count_r == $past(count_r) + 16'h0001)
    else $error("Up step missed.");

  a_down_step: assert property (@(posedge clk) disable iff (!nrst)  // [RL5]
    (clkEn && run_r && step && down && !wrap)
      |=> count_r == $past(count_r) - 16'h0001)
    else $error("Down step missed.");

  a_normal_gate: assert property (@(posedge clk) disable iff (!nrst)  // [RL20]
    (twoPh && !x4 && !ouSync_r[1]) |-> !step)
    else $error("Normal two-phase counted with phase low.");

  a_normal_up: assert property (@(posedge clk) disable iff (!nrst)  // [RL20]
    (twoPh && !x4 && ouSync_r[1] && inRise) |-> step && !down)
    else $error("Normal two-phase rising edge not counted up.");

  a_x4_dir: assert property (@(posedge clk) disable iff (!nrst)  // [RL21]
    (twoPh && x4 && ouSync_r[1] && (inRise || inFall))
      |-> step && (down == inFall))
    else $error("Times-four direction wrong.");

  a_one_step_edge: assert property (@(posedge clk) disable iff (!nrst)  // [RL23]
    (clkEn && inRise) |=> !inRise)
    else $error("Input edge seen twice.");

  a_run_write: assert property (@(posedge clk) disable iff (!nrst)  // [RL9]
    (clkEn && isWr(req, TEC_OFS_START))
      |=> run_r == $past(req.wdata[TEC_START_RUN]))
    else $error("Run bit write lost.");

  a_enable_freeze: assert property (@(posedge clk) disable iff (!nrst)  // [RL9]
    !clkEn |=> $stable(count_r) && $stable(run_r))
    else $error("State moved with clock enable low.");

  a_wrap_pulse: assert property (@(posedge clk) disable iff (!nrst)  // [RL4]
    (clkEn && wrap) |=> wrapEvt)
    else $error("Missing wrap event pulse.");

  a_no_irq_idle: assert property (@(posedge clk) disable iff (!nrst)  // [RL10]
    (clkEn && !wrap) |=> !irqReq)
    else $error("Interrupt without wrap.");

  a_toggle_wrap: assert property (@(posedge clk) disable iff (!nrst)  // [RL14]
    (clkEn && wrap) |=> tog_r != $past(tog_r))
    else $error("Toggle state missed a wrap.");

  a_out_enable: assert property (@(posedge clk) disable iff (!nrst)  // [RL17]
    clkEn
      |=> outPinOe == ($past(mode_r[TEC_MODE_PULSE]) && !$past(twoPh)))
    else $error("Output enable wrong.");

  c_wrap_up: cover property (@(posedge clk) disable iff (!nrst) wrap && !down);
  c_wrap_down: cover property (@(posedge clk) disable iff (!nrst) wrap && down);
  c_two_phase: cover property (@(posedge clk) disable iff (!nrst) twoPh && step);
  c_running_write: cover property (@(posedge clk) disable iff (!nrst)
    run_r && isWr(req, TEC_OFS_VALUE));
  c_pin_step: cover property (@(posedge clk) disable iff (!nrst)
    !twoPh && src == TEC_SRC_PIN && step);

endmodule : tec_channel
`default_nettype wire

// >>> hw/tec_pkg.sv
// Package for the timer event counter channel: register map, fields, types.
// Assumes a single 100 MHz clock and a plain strobe register port.
package tec_pkg;

  localparam int TEC_AW = 4;
  localparam int TEC_DW = 16;

  // Register indices on the plain register port.
  localparam logic [3:0] TEC_OFS_START = 4'h0;  // count_start_flags_reg
  localparam logic [3:0] TEC_OFS_VALUE = 4'h1;  // channel_value_reg
  localparam logic [3:0] TEC_OFS_MODE  = 4'h2;  // channel_mode_reg
  localparam logic [3:0] TEC_OFS_PINS  = 4'h3;  // pin state, read only

  // Field positions in the start-flags register.
  localparam int TEC_START_RUN = 0;

  // Field positions in the mode register.
  localparam int TEC_MODE_SRC_LO   = 0;  // two bits: source select
  localparam int TEC_MODE_EDGE     = 2;  // 1: falling edge on count input
  localparam int TEC_MODE_DOWN     = 3;  // 1: count down
  localparam int TEC_MODE_FREE     = 4;  // 1: free-running, no reload
  localparam int TEC_MODE_PULSE    = 5;  // 1: pulse output on output pin
  localparam int TEC_MODE_INV      = 6;  // 1: output polarity inverted
  localparam int TEC_MODE_TWOPH    = 7;  // 1: two-phase processing
  localparam int TEC_MODE_X4       = 8;  // 1: multiply-by-four (channel 3)
  localparam int TEC_MODE_W        = 9;

  localparam logic [TEC_MODE_W-1:0] TEC_MODE_RST = 9'h000;
  localparam logic [15:0]           TEC_VALUE_RST = 16'h0000;
  localparam logic [15:0]           TEC_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0]           TEC_COUNT_MIN = 16'h0000;

  typedef enum logic [1:0] {
    TEC_SRC_PIN  = 2'b00,
    TEC_SRC_COMP = 2'b01,
    TEC_SRC_PREV = 2'b10,
    TEC_SRC_NEXT = 2'b11
  } tec_src_type;

  // Register port request.
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [TEC_AW-1:0] addr;
    logic [TEC_DW-1:0] wdata;
  } tec_req_type;

  // Events of neighbouring timers, each a one-cycle pulse.
  typedef struct packed {
    logic comp;
    logic prev;
    logic next;
  } tec_nbr_type;

endpackage : tec_pkg

// >>> sim/tec_evt_src.sv
// Far-side model: neighbour timer event pulses and the two external pin levels.
// Assumes its tasks are called from a process clocked by the same clk.
`timescale 1ns/10ps
`default_nettype none
module tec_evt_src
  import tec_pkg::*;
(
  input  wire logic  clk,
  output var tec_nbr_type nbrEvt,
  output logic        countInPin,
  output logic        outDrv
);
  initial begin
    nbrEvt = '0;
    countInPin = 1'b0;
    outDrv = 1'b0;
  end
  // One-cycle pulse; bit 2 companion, bit 1 preceding, bit 0 following.
  task automatic ev(input logic [2:0] k);
    @(posedge clk);
    nbrEvt <= k;
    @(posedge clk);
    nbrEvt <= '0;
  endtask
  // Pin levels are held long enough to pass the synchroniser and edge detect.
  task automatic pins(input logic a, input logic b);
    @(posedge clk);
    countInPin <= a;
    outDrv <= b;
    repeat (6) @(posedge clk);
  endtask
endmodule // tec_evt_src
`default_nettype wire

// >>> sim/tb_timer_event_counter_mode.sv
// Self-checking bench for the event counter channel, built as channel 3.
// Assumes the far-side model drives events and pins; clkEn drops once to check the freeze.
`timescale 1ns/10ps
`default_nettype none
module tb_timer_event_counter_mode import tec_pkg::*;;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        clkEn = 1'b1;
  logic        wrapEvt;
  logic [15:0] wrapN = 16'h0000;
  tec_req_type req = '0;
  logic [15:0] rdata;
  tec_nbr_type nbrEvt;
  logic        countInPin;
  logic        outDrv;
  logic        outPinOut;
  logic        outPinOe;
  logic        irqReq;
  logic [15:0] irqN = 16'h0000;
  int          failCount = 0;
  int          nCompared = 0;
  // The output pin carries the design's level while it drives, else the far side's.
  wire logic   outLvl = outPinOe ? outPinOut : outDrv;

  always #5 clk = ~clk;
  always_ff @(posedge clk) if (nrst && irqReq) irqN <= irqN + 16'h0001;
  always_ff @(posedge clk) if (nrst && wrapEvt) wrapN <= wrapN + 16'h0001;

  tec_channel #(.CHAN(3)) uut (.clk(clk), .nrst(nrst), .clkEn(clkEn), .req(req),
    .rdata(rdata), .nbrEvt(nbrEvt), .countInPin(countInPin), .outPinIn(outLvl),
    .outPinOut(outPinOut), .outPinOe(outPinOe), .wrapEvt(wrapEvt), .irqReq(irqReq));
  tec_evt_src src (.clk(clk), .nbrEvt(nbrEvt), .countInPin(countInPin),
    .outDrv(outDrv));

  task automatic finishTest();
    if (failCount == 0 && nCompared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic md(input logic [8:0] m);
    wr(TEC_OFS_MODE, {7'h00, m});
  endtask
  task automatic run(input logic b);
    wr(TEC_OFS_START, {15'h0000, b});
  endtask
  task automatic pinChk(input logic e);
    #1 chk({15'h0000, outPinOut}, {15'h0000, e});
  endtask

  initial begin
    #100000;
    failCount++;
    finishTest();
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(TEC_OFS_VALUE, TEC_VALUE_RST);
    rd(TEC_OFS_MODE, 16'h0000);
    rd(4'hF, 16'h0000);
    // Down count from the preceding channel with reload and pulse output.
    wr(TEC_OFS_VALUE, 16'h0002);
    rd(TEC_OFS_VALUE, 16'h0002);
    md(9'h02A);
    pinChk(1'b0);
    run(1'b1);
    repeat (2) src.ev(3'b010);
    rd(TEC_OFS_VALUE, 16'h0000);
    wr(TEC_OFS_VALUE, 16'h0005);
    rd(TEC_OFS_VALUE, 16'h0000);
    src.ev(3'b010);
    rd(TEC_OFS_VALUE, 16'h0005);
    chk(irqN, 16'h0001);
    pinChk(1'b1);
    chk({15'h0000, outPinOe}, 16'h0001);
    src.ev(3'b010);
    run(1'b0);
    src.ev(3'b010);
    rd(TEC_OFS_VALUE, 16'h0004);
    pinChk(1'b0);
    md(9'h06A);
    rd(TEC_OFS_VALUE, 16'h0004);
    pinChk(1'b1);
    // Up count from the following channel, free-running.
    wr(TEC_OFS_VALUE, 16'hFFFE);
    md(9'h013);
    run(1'b1);
    repeat (2) src.ev(3'b001);
    rd(TEC_OFS_VALUE, 16'h0000);
    chk(irqN, 16'h0002);
    chk(wrapN, 16'h0002);
    // Companion timer source; preceding channel events are ignored.
    run(1'b0);
    wr(TEC_OFS_VALUE, 16'h0010);
    md(9'h001);
    run(1'b1);
    src.ev(3'b100);
    src.ev(3'b010);
    rd(TEC_OFS_VALUE, 16'h0011);
    @(posedge clk) clkEn <= 1'b0;
    src.ev(3'b100);
    clkEn <= 1'b1;
    rd(TEC_OFS_VALUE, 16'h0011);
    // Count input pin, rising then falling edge.
    md(9'h000);
    src.pins(1'b1, 1'b0);
    src.pins(1'b0, 1'b0);
    rd(TEC_OFS_VALUE, 16'h0012);
    md(9'h004);
    src.pins(1'b1, 1'b0);
    src.pins(1'b0, 1'b0);
    rd(TEC_OFS_VALUE, 16'h0013);
    // Normal two-phase: counts only while the second phase is high.
    md(9'h0A0);
    src.pins(1'b0, 1'b1);
    src.pins(1'b1, 1'b1);
    src.pins(1'b1, 1'b0);
    src.pins(1'b0, 1'b0);
    rd(TEC_OFS_VALUE, 16'h0014);
    chk({15'h0000, outPinOe}, 16'h0000);
    src.pins(1'b0, 1'b1);
    src.pins(1'b1, 1'b1);
    src.pins(1'b0, 1'b1);
    rd(TEC_OFS_PINS, 16'h0002);
    rd(TEC_OFS_VALUE, 16'h0014);
    // Multiply-by-four: one full cycle with the second phase leading high counts up by four.
    src.pins(1'b0, 1'b0);
    md(9'h180);
    src.pins(1'b0, 1'b1);
    src.pins(1'b1, 1'b1);
    src.pins(1'b1, 1'b0);
    src.pins(1'b0, 1'b0);
    rd(TEC_OFS_VALUE, 16'h0018);
    finishTest();
  end
endmodule // tb_timer_event_counter_mode
`default_nettype wire
